/* rtl/svm_ctrl.sv */
// Setup sequencer that drives the supply-voltage monitor registers
`default_nettype none
// Overview of operation
// - Monitor-1 level is read only after detection-1 enable and the settling wait.
// - Detect-2 level is read only after detection-2 enable and the settling wait.
// - Monitor-0 filter bypass is set when stop-mode wake is wanted (filter off).
// - Filtered monitor-0 order ends with oscillator on, four sample waits, then the enable.
// - Unfiltered monitor-0 writes condition select 1 and filter-disable 1.
// - Monitor-0 reset enable is written 1 as the last step.
// - Divider, filter-disable and mode go in one write while disabled.
// - Monitor-1 filter bypass is set when stop-mode wake is wanted (filter off).
// - Comparator-function select is cleared before detection 1 is enabled.
// - Filtered monitor-1 waits two sampling clocks before the enable.
// - Monitor-1 crossing flag is cleared to 0 before the final enable.
// - Monitor-1 reset mode forces condition select to 1.
// - Monitor-1 event enable is written 1 as the last step.
// - Monitor-1 divider and filter select go in one write while disabled.
// - Oscillator stop bit is cleared before the filter wait and enable.
// - Edge-count bit is written before mode and condition select go in one write.
module svm_ctrl #(
	parameter int SETTLE_NS     = svm_pkg::SETTLE_NS_DEF,
	parameter int LSO_PERIOD_NS = svm_pkg::LSO_PERIOD_NS_DEF
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Wishbone slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatWr,
	output logic             wbAck,
	output logic [31:0]      wbDatRd,
	// Device register port
	output logic             devStb,
	output logic             devWe,
	output logic [7:0]       devAddr,
	output logic [7:0]       devWdata,
	input  wire logic [7:0]  devRdata,
	input  wire logic        devAck
);
	localparam int TW = svm_pkg::TIMER_W;
	localparam int P  = svm_pkg::CLK_PERIOD_NS;
	localparam logic [TW-1:0] SETTLE_CYC = TW'((SETTLE_NS + P - 1) / P);
	localparam logic [TW-1:0] LSO_CYC    = TW'((LSO_PERIOD_NS + P - 1) / P);

	svm_pkg::svm_regs_t r;
	svm_pkg::svm_regs_t n;
	svm_pkg::svm_op_t   op;
	logic [TW-1:0]      waitVal;
	logic               timerLoad;
	logic               timerExpired;
	logic               wbWrite;
	logic               startReq;
	logic [9:0]         newCmd;
	logic [31:0]        rdWord;

	// Filter wait in system clocks: samples times the divided oscillator period
	function automatic logic [TW-1:0] sampleWait(input logic [2:0] samples,
		input logic [1:0] div);
		logic [TW-1:0] period;
		period = LSO_CYC << div;
		return TW'(samples * period);
	endfunction

	// Monitor control byte; a 1 in the flag position leaves the flag alone
	function automatic logic [7:0] ctlByte(input logic en, input logic filtDis,
		input logic flag, input logic [1:0] div, input logic mode, input logic cond);
		logic [7:0] b;
		b = 8'h00;
		b[svm_pkg::CTL_EN] = en;
		b[svm_pkg::CTL_FILT_DIS] = filtDis;
		b[svm_pkg::CTL_FLAG] = flag;
		b[svm_pkg::CTL_DIV_LO +: 2] = div;
		b[svm_pkg::CTL_MODE] = mode;
		b[svm_pkg::CTL_COND] = cond;
		return b;
	endfunction

	function automatic svm_pkg::svm_op_t mkOp(input svm_pkg::svm_opkind_t k,
		input logic [7:0] a, input logic [7:0] s, input logic [7:0] c);
		svm_pkg::svm_op_t o;
		o = '0;
		o.kind = k;
		o.addr = a;
		o.setB = s;
		o.clrB = c;
		return o;
	endfunction

	// One step of the selected setup sequence
	function automatic svm_pkg::svm_op_t stepOp(input logic [9:0] c, input logic [3:0] s);
		svm_pkg::svm_op_t o;
		logic             filt;
		logic [1:0]       dv;
		logic             m0cond;
		logic             m1mode;
		logic             m1cond;
		logic [7:0]       oscMask;
		o = mkOp(svm_pkg::OP_END, 8'h00, 8'h00, 8'h00);
		filt = c[svm_pkg::CMD_FILT];
		dv = c[svm_pkg::CMD_DIV_LO +: 2];
		m0cond = filt ? c[svm_pkg::CMD_COND] : 1'b1;
		m1mode = c[svm_pkg::CMD_RESET];
		m1cond = c[svm_pkg::CMD_RESET] | c[svm_pkg::CMD_COND];
		oscMask = 8'h00;
		oscMask[svm_pkg::SYSCLK_OSC_STOP] = 1'b1;
		if (c[svm_pkg::CMD_LEVELS]) begin
			// Only levels one and two exist to be read
			case (s)
				4'h0: o = mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_DETECT_ENABLE, 8'hC0, 8'h00);
				4'h1: o = mkOp(svm_pkg::OP_SETTLE, 8'h00, 8'h00, 8'h00);
				4'h2: o = mkOp(svm_pkg::OP_RD1, svm_pkg::DEV_MON1_CONTROL, 8'h00, 8'h00);
				4'h3: o = mkOp(svm_pkg::OP_RD2, svm_pkg::DEV_DETECT_STATUS, 8'h00, 8'h00);
				default: o = mkOp(svm_pkg::OP_END, 8'h00, 8'h00, 8'h00);
			endcase
		end else if (!c[svm_pkg::CMD_MON]) begin
			case (s)
				4'h0: o = mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_DETECT_ENABLE, 8'h20, 8'h00);
				4'h1: o = mkOp(svm_pkg::OP_SETTLE, 8'h00, 8'h00, 8'h00);
				// Divider, filter mode and reset mode in one write
				4'h2: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON0_CONTROL,
					ctlByte(1'b0, ~filt, 1'b1, dv, 1'b1, m0cond), 8'h00);
				4'h3: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON0_CONTROL,
					ctlByte(1'b0, ~filt, 1'b0, dv, 1'b1, m0cond), 8'h00);
				4'h4: o = filt ? mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_SYSCLK_CTRL, 8'h00, oscMask)
					: mkOp(svm_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
				4'h5: begin
					o = mkOp(filt ? svm_pkg::OP_SAMPLE : svm_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
					o.samples = svm_pkg::MON0_SAMPLE_WAIT;
				end
				4'h6: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON0_CONTROL,
					ctlByte(1'b1, ~filt, 1'b0, dv, 1'b1, m0cond), 8'h00);
				default: o = mkOp(svm_pkg::OP_END, 8'h00, 8'h00, 8'h00);
			endcase
		end else begin
			case (s)
				4'h0: o = mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_PIN_SELECT, 8'h00, 8'h01);
				4'h1: o = mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_DETECT_ENABLE, 8'h40, 8'h00);
				4'h2: o = mkOp(svm_pkg::OP_SETTLE, 8'h00, 8'h00, 8'h00);
				// Divider and filter select in one write
				4'h3: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON1_CONTROL,
					ctlByte(1'b0, ~filt, 1'b1, dv, 1'b0, 1'b0), 8'h00);
				4'h4: o = mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_EDGE_COUNT,
					{6'h00, c[svm_pkg::CMD_EDGE], 1'b0},
					{6'h00, ~c[svm_pkg::CMD_EDGE], 1'b0});
				4'h5: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON1_CONTROL,
					ctlByte(1'b0, ~filt, 1'b1, dv, m1mode, m1cond), 8'h00);
				4'h6: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON1_CONTROL,
					ctlByte(1'b0, ~filt, 1'b0, dv, m1mode, m1cond), 8'h00);
				4'h7: o = filt ? mkOp(svm_pkg::OP_RMW, svm_pkg::DEV_SYSCLK_CTRL, 8'h00, oscMask)
					: mkOp(svm_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
				4'h8: begin
					o = mkOp(filt ? svm_pkg::OP_SAMPLE : svm_pkg::OP_NOP, 8'h00, 8'h00, 8'h00);
					o.samples = svm_pkg::MON1_SAMPLE_WAIT;
				end
				4'h9: o = mkOp(svm_pkg::OP_WR, svm_pkg::DEV_MON1_CONTROL,
					ctlByte(1'b1, ~filt, 1'b0, dv, m1mode, m1cond), 8'h00);
				default: o = mkOp(svm_pkg::OP_END, 8'h00, 8'h00, 8'h00);
			endcase
		end
		return o;
	endfunction

	svm_timer u_timer (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.load      (timerLoad),
		.loadValue (waitVal),
		.expired   (timerExpired)
	);

	always_comb begin
		n = r;
		op = stepOp(r.cmd, r.step);
		if (op.kind == svm_pkg::OP_SETTLE) begin
			waitVal = SETTLE_CYC;
		end else begin
			waitVal = sampleWait(op.samples, r.cmd[svm_pkg::CMD_DIV_LO +: 2]);
		end
		timerLoad = (r.state == svm_pkg::ST_FETCH) &&
			((op.kind == svm_pkg::OP_SETTLE) || (op.kind == svm_pkg::OP_SAMPLE));
		wbWrite = wbCyc & wbStb & wbWe & r.wbAck;
		newCmd = r.cmd;
		if (wbSel[0]) begin
			newCmd[7:0] = wbDatWr[7:0];
		end
		if (wbSel[1]) begin
			newCmd[9:8] = wbDatWr[9:8];
		end
		startReq = wbWrite && (wbAdr == svm_pkg::ADR_CMD) && wbSel[0] &&
			wbDatWr[svm_pkg::CMD_START];

		// Wishbone answer one cycle after the request
		n.wbAck = wbCyc & wbStb & ~r.wbAck;
		rdWord = 32'h0000_0000;
		case (wbAdr)
			svm_pkg::ADR_CMD: rdWord[9:0] = {r.cmd[9:1], 1'b0};
			svm_pkg::ADR_STATUS: begin
				rdWord[svm_pkg::ST_BUSY] = r.busy;
				rdWord[svm_pkg::ST_DONE] = r.done;
				rdWord[svm_pkg::ST_REFUSED] = r.refused;
				rdWord[svm_pkg::ST_LEVEL1] = r.level1;
				rdWord[svm_pkg::ST_LEVEL2] = r.level2;
				rdWord[svm_pkg::ST_VALID] = r.valid;
			end
			default: rdWord = 32'h0000_0000;
		endcase
		n.wbDat = n.wbAck ? rdWord : 32'h0000_0000;

		// Sequencer
		case (r.state)
			svm_pkg::ST_IDLE: begin
				n.waitCyc = '0;
			end
			svm_pkg::ST_FETCH: begin
				n.waitCyc = '0;
				n.devAddr = op.addr;
				case (op.kind)
					svm_pkg::OP_NOP: n.step = r.step + 4'h1;
					svm_pkg::OP_RMW, svm_pkg::OP_RD1, svm_pkg::OP_RD2: begin
						n.devStb = 1'b1;
						n.devWe = 1'b0;
						n.state = svm_pkg::ST_RD;
					end
					svm_pkg::OP_WR: begin
						n.devStb = 1'b1;
						n.devWe = 1'b1;
						n.devWdata = op.setB;
						n.state = svm_pkg::ST_WR;
					end
					svm_pkg::OP_SETTLE, svm_pkg::OP_SAMPLE: begin
						n.waitLen = waitVal;
						n.state = svm_pkg::ST_WAIT;
					end
					default: begin
						n.busy = 1'b0;
						n.done = 1'b1;
						n.state = svm_pkg::ST_IDLE;
					end
				endcase
			end
			svm_pkg::ST_RD: begin
				if (devAck) begin
					n.devStb = 1'b0;
					if (op.kind == svm_pkg::OP_RMW) begin
						n.devWdata = (devRdata & ~op.clrB) | op.setB;
						n.state = svm_pkg::ST_PREP;
					end else begin
						if (op.kind == svm_pkg::OP_RD1) begin
							n.level1 = devRdata[svm_pkg::CTL_LEVEL];
						end else begin
							n.level2 = devRdata[svm_pkg::DET2_LEVEL];
							n.valid = 1'b1;
						end
						n.step = r.step + 4'h1;
						n.state = svm_pkg::ST_FETCH;
					end
				end
			end
			svm_pkg::ST_PREP: begin
				n.devStb = 1'b1;
				n.devWe = 1'b1;
				n.state = svm_pkg::ST_WR;
			end
			svm_pkg::ST_WR: begin
				if (devAck) begin
					n.devStb = 1'b0;
					n.devWe = 1'b0;
					n.step = r.step + 4'h1;
					n.state = svm_pkg::ST_FETCH;
				end
			end
			svm_pkg::ST_WAIT: begin
				n.waitCyc = r.waitCyc + 1'b1;
				if (timerExpired) begin
					if (op.kind == svm_pkg::OP_SETTLE) begin
						n.settled = 1'b1;
					end
					n.step = r.step + 4'h1;
					n.state = svm_pkg::ST_FETCH;
				end
			end
			default: n.state = svm_pkg::ST_IDLE;
		endcase

		// Command register; a start while busy is refused
		if (wbWrite && (wbAdr == svm_pkg::ADR_CMD)) begin
			if (r.busy) begin
				if (startReq) begin
					n.refused = 1'b1;
				end
			end else begin
				n.cmd = newCmd;
				n.cmd[svm_pkg::CMD_START] = 1'b0;
				n.refused = 1'b0;
				if (startReq) begin
					n.busy = 1'b1;
					n.done = 1'b0;
					n.settled = 1'b0;
					n.step = 4'h0;
					n.state = svm_pkg::ST_FETCH;
					if (newCmd[svm_pkg::CMD_LEVELS]) begin
						n.valid = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			r <= svm_pkg::REGS_RST;
		end else begin
			r <= n;
		end
	end

	assign wbAck = r.wbAck;
	assign wbDatRd = r.wbDat;
	assign devStb = r.devStb;
	assign devWe = r.devWe;
	assign devAddr = r.devAddr;
	assign devWdata = r.devWdata;

	property p_m0NoFilt;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && r.devWe && r.devAddr == svm_pkg::DEV_MON0_CONTROL &&
			!r.cmd[svm_pkg::CMD_FILT]) |->
		(r.devWdata[svm_pkg::CTL_COND] && r.devWdata[svm_pkg::CTL_FILT_DIS]);
	endproperty
	a_m0NoFilt: assert property (p_m0NoFilt) else $error("m0 unfiltered bits wrong");

	property p_m1ResetCond;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && r.devWe && r.devAddr == svm_pkg::DEV_MON1_CONTROL &&
			r.devWdata[svm_pkg::CTL_MODE]) |-> r.devWdata[svm_pkg::CTL_COND];
	endproperty
	a_m1ResetCond: assert property (p_m1ResetCond) else $error("reset mode cond 0");

	property p_m0Enable;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && r.devWe && r.devAddr == svm_pkg::DEV_MON0_CONTROL &&
			r.devWdata[svm_pkg::CTL_EN]) |->
		(r.devWdata[svm_pkg::CTL_MODE] && !r.devWdata[svm_pkg::CTL_FLAG] && r.settled);
	endproperty
	a_m0Enable: assert property (p_m0Enable) else $error("m0 enable write bad");

	property p_m1Enable;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && r.devWe && r.devAddr == svm_pkg::DEV_MON1_CONTROL &&
			r.devWdata[svm_pkg::CTL_EN]) |-> !r.devWdata[svm_pkg::CTL_FLAG];
	endproperty
	a_m1Enable: assert property (p_m1Enable) else $error("m1 enabled, flag set");

	property p_oscOn;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && r.devWe && r.devAddr == svm_pkg::DEV_SYSCLK_CTRL) |->
		!r.devWdata[svm_pkg::SYSCLK_OSC_STOP];
	endproperty
	a_oscOn: assert property (p_oscOn) else $error("oscillator left stopped");

	property p_m0Wait;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.state == svm_pkg::ST_WAIT && op.kind == svm_pkg::OP_SAMPLE &&
			!r.cmd[svm_pkg::CMD_MON]) |->
		r.waitLen == TW'((LSO_CYC << r.cmd[svm_pkg::CMD_DIV_LO +: 2]) * 4);
	endproperty
	a_m0Wait: assert property (p_m0Wait) else $error("m0 filter wait wrong");

	property p_m1Wait;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.state == svm_pkg::ST_WAIT && op.kind == svm_pkg::OP_SAMPLE &&
			r.cmd[svm_pkg::CMD_MON]) |->
		r.waitLen == TW'((LSO_CYC << r.cmd[svm_pkg::CMD_DIV_LO +: 2]) * 2);
	endproperty
	a_m1Wait: assert property (p_m1Wait) else $error("m1 filter wait wrong");

	property p_waitLength;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.state == svm_pkg::ST_WAIT && timerExpired) |-> (r.waitCyc == r.waitLen);
	endproperty
	a_waitLength: assert property (p_waitLength) else $error("wait ended early");

	property p_level1Read;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && !r.devWe && r.devAddr == svm_pkg::DEV_MON1_CONTROL) |-> r.settled;
	endproperty
	a_level1Read: assert property (p_level1Read) else $error("level 1 read unsettled");

	property p_level2Read;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && !r.devWe && r.devAddr == svm_pkg::DEV_DETECT_STATUS) |-> r.settled;
	endproperty
	a_level2Read: assert property (p_level2Read) else $error("level 2 read unsettled");

	property p_devHold;
		@(posedge clk_sys) disable iff (!reset_n)
		(r.devStb && !devAck) |=> (r.devStb && $stable(r.devAddr) && $stable(r.devWe)
			&& $stable(r.devWdata));
	endproperty
	a_devHold: assert property (p_devHold) else $error("device request not held");
endmodule
`default_nettype wire

/* include/svm_pkg.sv */
// Shared constants and types for the supply-voltage monitor setup controller
`default_nettype none
package svm_pkg;
	// Clock and default analogue timings
	localparam int CLK_PERIOD_NS     = 25;
	localparam int SETTLE_NS_DEF     = 100000;
	localparam int LSO_PERIOD_NS_DEF = 8000;
	localparam int TIMER_W           = 24;

	// Own register map on the Wishbone side
	localparam logic [7:0] ADR_CMD    = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;

	// Command register fields
	localparam int CMD_W      = 10;
	localparam int CMD_START  = 0;
	localparam int CMD_MON    = 1;
	localparam int CMD_LEVELS = 2;
	localparam int CMD_FILT   = 3;
	localparam int CMD_RESET  = 4;
	localparam int CMD_COND   = 5;
	localparam int CMD_EDGE   = 6;
	localparam int CMD_DIV_LO = 8;

	// Status register fields
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_LEVEL1  = 3;
	localparam int ST_LEVEL2  = 4;
	localparam int ST_VALID   = 5;

	// Device register indexes on the device port
	localparam logic [7:0] DEV_DETECT_ENABLE = 8'h00;
	localparam logic [7:0] DEV_DETECT_STATUS = 8'h01;
	localparam logic [7:0] DEV_MON0_CONTROL  = 8'h02;
	localparam logic [7:0] DEV_MON1_CONTROL  = 8'h03;
	localparam logic [7:0] DEV_EDGE_COUNT    = 8'h04;
	localparam logic [7:0] DEV_PIN_SELECT    = 8'h05;
	localparam logic [7:0] DEV_SYSCLK_CTRL   = 8'h06;

	// Device register bit positions
	localparam int DET0_EN         = 5;
	localparam int DET1_EN         = 6;
	localparam int DET2_EN         = 7;
	localparam int DET2_LEVEL      = 3;
	localparam int CTL_EN          = 0;
	localparam int CTL_FILT_DIS    = 1;
	localparam int CTL_FLAG        = 2;
	localparam int CTL_LEVEL       = 3;
	localparam int CTL_DIV_LO      = 4;
	localparam int CTL_MODE        = 6;
	localparam int CTL_COND        = 7;
	localparam int EDGE_MON1       = 1;
	localparam int PINSEL_COMP     = 0;
	localparam int SYSCLK_OSC_STOP = 4;

	// Filter sampling clock waits before the final enable
	localparam logic [2:0] MON0_SAMPLE_WAIT = 3'h4;
	localparam logic [2:0] MON1_SAMPLE_WAIT = 3'h2;

	typedef enum logic [2:0] {
		OP_NOP    = 3'h0,
		OP_RMW    = 3'h1,
		OP_WR     = 3'h2,
		OP_RD1    = 3'h3,
		OP_RD2    = 3'h4,
		OP_SETTLE = 3'h5,
		OP_SAMPLE = 3'h6,
		OP_END    = 3'h7
	} svm_opkind_t;

	typedef struct packed {
		svm_opkind_t kind;
		logic [7:0]  addr;
		logic [7:0]  setB;
		logic [7:0]  clrB;
		logic [2:0]  samples;
	} svm_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FETCH = 3'h1,
		ST_RD    = 3'h3,
		ST_PREP  = 3'h7,
		ST_WR    = 3'h5,
		ST_WAIT  = 3'h4
	} svm_state_t;

	typedef struct packed {
		svm_state_t         state;
		logic [3:0]         step;
		logic [CMD_W-1:0]   cmd;
		logic               busy;
		logic               done;
		logic               refused;
		logic               level1;
		logic               level2;
		logic               valid;
		logic               settled;
		logic               wbAck;
		logic [31:0]        wbDat;
		logic               devStb;
		logic               devWe;
		logic [7:0]         devAddr;
		logic [7:0]         devWdata;
		logic [TIMER_W-1:0] waitLen;
		logic [TIMER_W-1:0] waitCyc;
	} svm_regs_t;

	typedef struct packed {
		logic [TIMER_W-1:0] cnt;
		logic               expired;
	} svm_timer_regs_t;

	localparam svm_regs_t       REGS_RST  = '0;
	localparam svm_timer_regs_t TIMER_RST = '0;
endpackage
`default_nettype wire

/* rtl/svm_timer.sv */
// Down-counting wait timer for settling and filter sampling waits
`default_nettype none
module svm_timer (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        reset_n,
	// Load and expiry
	input  wire logic                        load,
	input  wire logic [svm_pkg::TIMER_W-1:0] loadValue,
	output logic                             expired
);
	svm_pkg::svm_timer_regs_t r;
	svm_pkg::svm_timer_regs_t n;

	always_comb begin
		n = r;
		if (load) begin
			n.cnt = loadValue;
			n.expired = 1'b0;
		end else if (r.cnt != '0) begin
			n.cnt = r.cnt - 1'b1;
			n.expired = (r.cnt == {{(svm_pkg::TIMER_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			r <= svm_pkg::TIMER_RST;
		end else begin
			r <= n;
		end
	end

	assign expired = r.expired;
endmodule
`default_nettype wire

/* verification/svm_dev_model.sv */
// Behavioural model of the monitored device register file
`default_nettype none
module svm_dev_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// Register port
	input  wire logic       devStb,
	input  wire logic       devWe,
	input  wire logic [7:0] devAddr,
	input  wire logic [7:0] devWdata,
	output logic            devAck,
	output logic [7:0]      devRdata,
	// Comparator levels and answer latency
	input  wire logic       level1In,
	input  wire logic       level2In,
	input  wire logic [1:0] lat
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] regs [0:6];
	logic [7:0] rd;
	logic [1:0] cnt;
	logic [2:0] a;
	logic [1:0] l1Smp;
	logic       l1Filt;
	logic       l1Seen;
	assign a = devAddr[2:0];
	// Filter on: the level moves only after two equal samples in a row
	always_ff @(posedge clk_sys) begin
		l1Smp <= {l1Smp[0], level1In};
		if (l1Smp[1] == l1Smp[0]) l1Filt <= l1Smp[0];
	end
	assign l1Seen = regs[3][1] ? level1In : l1Filt;
	// Released read bus shows the inverse of the last value
	assign devRdata = devAck ? rd : ~rd;
	always_ff @(posedge clk_sys) begin
		// Only power-on reset exists here; no other reset clears flag or level
		if (!reset_n) begin
			devAck <= 1'b0;
			cnt    <= 2'h0;
			rd     <= 8'h00;
			for (int i = 0; i < 7; i++) regs[i] <= 8'h00;
		end else if (devAck || !devStb) begin
			devAck <= 1'b0;
			cnt    <= 2'h0;
		end else if (cnt != lat) begin
			cnt <= cnt + 2'h1;
		end else begin
			devAck <= 1'b1;
			if (devWe && devAddr < 8'h07)
				regs[a] <= (a == 3'h2 || a == 3'h3) ?
					{devWdata[7:3], devWdata[2] & regs[a][2], devWdata[1:0]} : devWdata;
			else if (!devWe) begin
				case (devAddr)
					8'h01: rd <= {4'h0, level2In & regs[0][7], 3'h0};
					8'h03: rd <= {regs[3][7:4], l1Seen & regs[0][6], regs[3][2:0]};
					default: rd <= devAddr < 8'h07 ? regs[a] : 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* verification/svm_ctrl_tb_top.sv */
// Self-checking bench for the monitor setup controller
`default_nettype none
module svm_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SETTLE = 10;
	localparam int LSO = 4;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDatWr = 32'h0;
	logic        wbAck, devStb, devWe, devAck;
	logic [31:0] wbDatRd;
	logic [7:0]  devAddr, devWdata, devRdata;
	logic        level1In = 1'b0, level2In = 1'b0;
	logic [1:0]  lat = 2'h0;
	logic [3:0]  wbSel = 4'hF;
	int          errTotal = 0, numChecks = 0, cyc = 0, seed = 32'h01e5718d;
	logic [7:0]  sh [0:6] = '{default: 8'h00};
	logic [7:0]  expA [$], expD [$], gotA [$], gotD [$];
	int          gotT [$];

	svm_ctrl #(.SETTLE_NS(250), .LSO_PERIOD_NS(100)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatWr(wbDatWr), .wbAck(wbAck), .wbDatRd(wbDatRd), .devStb(devStb), .devWe(devWe),
		.devAddr(devAddr), .devWdata(devWdata), .devRdata(devRdata), .devAck(devAck));
	svm_dev_model dev (.clk_sys(clk_sys), .reset_n(reset_n), .devStb(devStb), .devWe(devWe),
		.devAddr(devAddr), .devWdata(devWdata), .devAck(devAck), .devRdata(devRdata),
		.level1In(level1In), .level2In(level2In), .lat(lat));

	initial forever #12.5 clk_sys = ~clk_sys;

	// Log of device writes with the cycle of their answer
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (devStb === 1'b1 && devAck === 1'b1 && devWe === 1'b1) begin
			gotA.push_back(devAddr);
			gotD.push_back(devWdata);
			gotT.push_back(cyc);
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbCyc   <= 1'b1;
		wbStb   <= 1'b1;
		wbWe    <= we;
		wbAdr   <= adr;
		wbDatWr <= dat;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (n == 50) errTotal++;
		rd = wbDatRd;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic pw(input logic [7:0] a, input logic [7:0] d);
		expA.push_back(a);
		expD.push_back(d);
		sh[a[2:0]] = d;
	endtask

	// Expected device writes for one command
	task automatic build_exp(input logic [9:0] c);
		logic [7:0] k;
		if (c[2]) pw(8'h00, sh[0] | 8'hC0);
		else if (!c[1]) begin
			pw(8'h00, sh[0] | 8'h20);
			k = {c[3] ? c[5] : 1'b1, 1'b1, c[9:8], 1'b0, 1'b1, !c[3], 1'b0};
			pw(8'h02, k);
			pw(8'h02, k & 8'hFB);
			if (c[3]) pw(8'h06, sh[6] & 8'hEF);
			pw(8'h02, k & 8'hFB | 8'h01);
		end else begin
			pw(8'h05, sh[5] & 8'hFE);
			pw(8'h00, sh[0] | 8'h40);
			k = {2'b00, c[9:8], 1'b0, 1'b1, !c[3], 1'b0};
			pw(8'h03, k);
			pw(8'h04, sh[4] & 8'hFD | {6'h0, c[6], 1'b0});
			k = {c[4] | c[5], c[4], k[5:0]};
			pw(8'h03, k);
			pw(8'h03, k & 8'hFB);
			if (c[3]) pw(8'h06, sh[6] & 8'hEF);
			pw(8'h03, k & 8'hFB | 8'h01);
		end
	endtask

	task automatic run_cmd(input logic [9:0] c, input logic dup);
		logic [31:0] st;
		int n, j, k;
		gotA = {};
		gotD = {};
		gotT = {};
		expA = {};
		expD = {};
		build_exp(c);
		wb(1'b1, 8'h00, {22'h0, c}, st);
		if (dup) wb(1'b1, 8'h00, {22'h0, c}, st);
		n = 0;
		do begin
			wb(1'b0, 8'h04, 32'h0, st);
			n++;
		end while (st[1:0] !== 2'b10 && n < 500);
		check(st[2:0], {dup, 2'b10});
		if (c[2]) check(st[5:3], {1'b1, level2In, level1In});
		check(gotA.size(), expA.size());
		if (gotA.size() == expA.size()) begin
			foreach (expA[i]) check({gotA[i], gotD[i]}, {expA[i], expD[i]});
			k = gotT.size() - 1;
			j = c[1];
			if (!c[2]) check(gotT[j + 1] - gotT[j] >= SETTLE, 1'b1);
			if (!c[2] && c[3]) check(gotT[k] - gotT[k - 1] >= (c[1] ? 2 : 4) * (LSO << c[9:8]),
				1'b1);
		end
		wb(1'b0, 8'h00, 32'h0, st);
		check(st, {22'h0, c[9:1], 1'b0});
		if (dup) begin
			wb(1'b1, 8'h00, 32'h0, st);
			wb(1'b0, 8'h04, 32'h0, st);
			check(st[2], 1'b0);
		end
	endtask

	initial begin
		#2_000_000;
		errTotal++;
		print_verdict();
	end

	initial begin
		logic [31:0] rd;
		logic [9:0]  c;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		wb(1'b0, 8'h00, 32'h0, rd);
		check(rd, 32'h0);
		wb(1'b1, 8'h08, 32'hFFFFFFFF, rd);
		wb(1'b0, 8'h08, 32'h0, rd);
		check(rd, 32'h0);
		wb(1'b1, 8'h04, 32'h3F, rd);
		wb(1'b0, 8'h04, 32'h0, rd);
		check(rd, 32'h0);
		// Byte lane 0 off: start and bits 7:0 stay, bits 9:8 land
		wbSel <= 4'hE;
		wb(1'b1, 8'h00, 32'h3FF, rd);
		wbSel <= 4'hF;
		wb(1'b0, 8'h00, 32'h0, rd);
		check(rd, 32'h300);
		// Every mode and filter choice against every divider code
		for (int i = 0; i < 32; i++) begin
			c = 10'($random(seed));
			c = {i[4:3], 1'b0, c[6:4], i[2:0], 1'b1};
			level1In <= 1'($random(seed));
			level2In <= 1'($random(seed));
			lat <= 2'($random(seed));
			run_cmd(c, 1'b0);
		end
		run_cmd(10'h30B, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
